// *** common/cce_pkg.sv ***
// shared types and constants for the compare/clear/complement/adjust/decrement unit
package cce_pkg;

    // ------------------------------------------------------------
    // opcode encodings
    // ------------------------------------------------------------
    localparam logic [3:0] CMPBR_HI = 4'hB;
    localparam logic [3:0] DECR_HI = 4'h1;
    localparam logic [3:0] LO_ACC_IMM = 4'h4;
    localparam logic [3:0] LO_DIRECT = 4'h5;
    localparam logic [2:0] LO_INDIRECT = 3'h3;
    localparam logic [7:0] OP_ZERO_ACC = 8'hE4;
    localparam logic [7:0] OP_INV_ACC = 8'hF4;
    localparam logic [7:0] OP_ADJ_ACC = 8'hD4;
    localparam logic [7:0] OP_ZERO_BIT = 8'hC2;
    localparam logic [7:0] OP_ZERO_CARRY = 8'hC3;
    localparam logic [7:0] OP_INV_BIT = 8'hB2;
    localparam logic [7:0] OP_INV_CARRY = 8'hB3;

    // ------------------------------------------------------------
    // lengths, cycle counts and arithmetic constants
    // ------------------------------------------------------------
    localparam logic [15:0] LEN_ONE = 16'h0001;
    localparam logic [15:0] LEN_TWO = 16'h0002;
    localparam logic [15:0] LEN_CMPBR = 16'h0003;
    localparam int STATES_PER_CYCLE = 6;
    localparam int CMPBR_CYCLES = 2;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [8:0] BCD_LO_FIX = 9'h006;
    localparam logic [8:0] BCD_HI_FIX = 9'h060;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        DST_NONE,
        DST_ACC,
        DST_DIRECT,
        DST_INDIRECT,
        DST_REG,
        DST_BIT
    } cce_dst_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] byte2;
        logic [7:0] byte3;
        logic [15:0] pc;
    } cce_issue_t;

    typedef struct packed {
        logic wr_en;
        cce_dst_t wr_dst;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
        logic illegal;
    } cce_result_t;

endpackage : cce_pkg

// *** core/cce_dec_adj.sv ***
// decimal adjust of the accumulator after a packed-bcd addition
`timescale 1ns/1ps
module cce_dec_adj
    import cce_pkg::*;
(
    // operands
    input wire logic [7:0] acc,
    input wire logic aux_carry_flag,
    input wire logic carry_flag,
    // result
    output logic [7:0] result,
    output logic carry_out
);
    logic lo_fix;
    logic [8:0] step1;
    logic carry1;
    logic hi_fix;
    logic [8:0] step2;

    assign lo_fix = (acc[3:0] > BCD_MAX) || aux_carry_flag;
    assign step1 = {1'b0, acc} + (lo_fix ? BCD_LO_FIX : 9'h000);
    // carry may only be set by either step, never cleared
    assign carry1 = carry_flag | step1[8];
    assign hi_fix = (step1[7:4] > BCD_MAX) || carry1;
    assign step2 = {1'b0, step1[7:0]} + (hi_fix ? BCD_HI_FIX : 9'h000);
    assign result = step2[7:0];
    assign carry_out = carry1 | step2[8];
endmodule : cce_dec_adj

// *** core/cce_exec.sv ***
// execution unit for compare-branch, clear, complement, decimal adjust and decrement
// Function
// - branch adds displacement after pc plus three when unequal
// - carry set when first below second, else cleared
// - four compare operand pairings supported
// - compare opcodes 1011 01xx and 1011 1xxx, three bytes, two cycles
// - clear accumulator in one cycle, flags kept
// - clear carry or addressable bit in one cycle
// - invert accumulator in one cycle, flags kept
// - invert carry or bit; carry only if operand
// - port read-modify-write uses output latch value
// - low nibble adjust adds six, only sets carry
// - high nibble adjust adds six, overflow untouched
// - whole decimal adjust in one cycle
// - decrement wraps, leaves all flags alone
// - decrement on accumulator, direct, indirect, register
`timescale 1ns/1ps
module cce_exec
    import cce_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // instruction issue
    input wire logic issue_valid,
    input wire cce_issue_t issue,
    // operand values
    input wire logic [7:0] acc_in,
    input wire logic carry_in,
    input wire logic aux_carry_in,
    input wire logic [7:0] opnd_pin,
    input wire logic [7:0] opnd_latch,
    input wire logic opnd_is_port,
    // completion
    output logic ready_r,
    output logic done_r,
    output cce_result_t res_r,
    output logic [15:0] pc_next_r,
    output logic carry_r,
    output logic carry_we_r
);
    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    typedef enum logic {ST_IDLE, ST_SECOND} cce_state_t;
    cce_state_t state_r;

    wire [7:0] op = issue.opcode;
    wire [3:0] hi = op[7:4];
    wire [3:0] lo = op[3:0];
    wire form_acc = (lo == LO_ACC_IMM);
    wire form_dir = (lo == LO_DIRECT);
    wire form_ind = (lo[3:1] == LO_INDIRECT);
    wire form_reg = lo[3];
    wire form_ok = form_acc | form_dir | form_ind | form_reg;
    wire is_cmpbr = (hi == CMPBR_HI) && form_ok;
    wire is_decr = (hi == DECR_HI) && form_ok;
    wire is_clra = (op == OP_ZERO_ACC);
    wire is_cpla = (op == OP_INV_ACC);
    wire is_adj = (op == OP_ADJ_ACC);
    wire is_clrb = (op == OP_ZERO_BIT);
    wire is_clrc = (op == OP_ZERO_CARRY);
    wire is_cplb = (op == OP_INV_BIT);
    wire is_cplc = (op == OP_INV_CARRY);
    wire known = is_cmpbr | is_decr | is_clra | is_cpla | is_adj | is_clrb | is_clrc | is_cplb
        | is_cplc;
    wire take = issue_valid && ready_r && (state_r == ST_IDLE);

    // ------------------------------------------------------------
    // compare and branch
    // ------------------------------------------------------------
    // first operand: accumulator, or the indirect/register byte fetched outside
    wire [7:0] cj_a = (form_acc | form_dir) ? acc_in : opnd_pin;
    // compare reads pins, not the latch: it does not write the operand back
    wire [7:0] cj_b = form_dir ? opnd_pin : issue.byte2;
    wire cj_ne = (cj_a != cj_b);
    wire cj_lt = (cj_a < cj_b);
    wire [15:0] pc_after = issue.pc + LEN_CMPBR;
    wire [15:0] rel_ext = {{8{issue.byte3[7]}}, issue.byte3};
    wire [15:0] cj_target = cj_ne ? (pc_after + rel_ext) : pc_after;

    // ------------------------------------------------------------
    // decrement and bit operand sources
    // ------------------------------------------------------------
    // read-modify-write of a port must start from the output latch
    wire [7:0] mem_src = opnd_is_port ? opnd_latch : opnd_pin;
    wire [7:0] dec_src = form_acc ? acc_in : mem_src;
    wire [7:0] dec_val = dec_src - BYTE_ONE;
    wire [7:0] ptr_addr = {7'h00, op[0]};
    wire [7:0] reg_addr = {5'h00, op[2:0]};
    wire [7:0] bit_inv = {7'h00, ~mem_src[0]};

    // ------------------------------------------------------------
    // decimal adjust
    // ------------------------------------------------------------
    wire [7:0] da_val;
    wire da_carry;

    cce_dec_adj u_dec_adj (
        .acc(acc_in),
        .aux_carry_flag(aux_carry_in),
        .carry_flag(carry_in),
        .result(da_val),
        .carry_out(da_carry)
    );

    // ------------------------------------------------------------
    // result selection
    // ------------------------------------------------------------
    cce_result_t res_nxt;
    logic [15:0] pc_nxt;
    logic carry_nxt;
    logic carry_we_nxt;

    always_comb begin
        res_nxt = '{wr_en: 1'b0, wr_dst: DST_NONE, wr_addr: BYTE_ZERO, wr_data: BYTE_ZERO,
            illegal: ~known};
        pc_nxt = issue.pc + LEN_ONE;
        carry_nxt = carry_in;
        carry_we_nxt = 1'b0;
        if (is_cmpbr) begin
            // operands are never written back
            pc_nxt = cj_target;
            carry_nxt = cj_lt;
            carry_we_nxt = 1'b1;
        end else if (is_decr) begin
            res_nxt.wr_en = 1'b1;
            res_nxt.wr_data = dec_val;
            if (form_acc) begin
                res_nxt.wr_dst = DST_ACC;
            end else if (form_dir) begin
                res_nxt.wr_dst = DST_DIRECT;
                res_nxt.wr_addr = issue.byte2;
                pc_nxt = issue.pc + LEN_TWO;
            end else if (form_ind) begin
                res_nxt.wr_dst = DST_INDIRECT;
                res_nxt.wr_addr = ptr_addr;
            end else begin
                res_nxt.wr_dst = DST_REG;
                res_nxt.wr_addr = reg_addr;
            end
        end else if (is_clra | is_cpla | is_adj) begin
            res_nxt.wr_en = 1'b1;
            res_nxt.wr_dst = DST_ACC;
            if (is_clra) begin
                res_nxt.wr_data = BYTE_ZERO;
            end else if (is_cpla) begin
                res_nxt.wr_data = ~acc_in;
            end else begin
                res_nxt.wr_data = da_val;
                carry_nxt = da_carry;
                carry_we_nxt = 1'b1;
            end
        end else if (is_clrb | is_cplb) begin
            res_nxt.wr_en = 1'b1;
            res_nxt.wr_dst = DST_BIT;
            res_nxt.wr_addr = issue.byte2;
            res_nxt.wr_data = is_cplb ? bit_inv : BYTE_ZERO;
            pc_nxt = issue.pc + LEN_TWO;
        end else if (is_clrc | is_cplc) begin
            carry_nxt = is_cplc ? ~carry_in : 1'b0;
            carry_we_nxt = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    // compare-branch holds ready low for its second machine cycle
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_r <= ST_IDLE;
            ready_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    ready_r <= ~(take & is_cmpbr);
                    done_r <= take & ~is_cmpbr;
                    if (take && is_cmpbr) begin
                        state_r <= ST_SECOND;
                    end
                end
                ST_SECOND: begin
                    state_r <= ST_IDLE;
                    ready_r <= 1'b1;
                    done_r <= 1'b1;
                end
                default: begin
                    state_r <= ST_IDLE;
                    ready_r <= 1'b1;
                    done_r <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            res_r <= '0;
            pc_next_r <= 16'h0000;
            carry_r <= 1'b0;
            carry_we_r <= 1'b0;
        end else if (take) begin
            res_r <= res_nxt;
            pc_next_r <= pc_nxt;
            carry_r <= carry_nxt;
            carry_we_r <= carry_we_nxt;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_cmpbr_done;
        !done_r ##1 done_r;
    endsequence

    property p_cmpbr_pc;
        @(posedge core_clk) disable iff (!nrst)
        take && is_cmpbr |=> s_cmpbr_done ##0 (pc_next_r == ($past(cj_ne, 2) ?
            $past(issue.pc, 2) + 16'h0003 + {{8{$past(issue.byte3[7], 2)}},
            $past(issue.byte3, 2)} : $past(issue.pc, 2) + 16'h0003));
    endproperty
    a_cmpbr_pc: assert property (p_cmpbr_pc) else $error("compare branch pc wrong");

    property p_cmpbr_carry;
        @(posedge core_clk) disable iff (!nrst)
        take && is_cmpbr |-> ##2 carry_we_r && !res_r.wr_en
            && (carry_r == ($past(cj_a, 2) < $past(cj_b, 2)));
    endproperty
    a_cmpbr_carry: assert property (p_cmpbr_carry) else $error("compare carry wrong");

    property p_cmpbr_busy;
        @(posedge core_clk) disable iff (!nrst)
        take && is_cmpbr |=> !ready_r ##1 ready_r;
    endproperty
    a_cmpbr_busy: assert property (p_cmpbr_busy) else $error("compare not two cycles");

    property p_clr_acc;
        @(posedge core_clk) disable iff (!nrst)
        take && is_clra |=> done_r && res_r.wr_dst == DST_ACC && res_r.wr_data == 8'h00
            && !carry_we_r;
    endproperty
    a_clr_acc: assert property (p_clr_acc) else $error("clear accumulator wrong");

    property p_cpl_acc;
        @(posedge core_clk) disable iff (!nrst)
        take && is_cpla |=> done_r && res_r.wr_data == ~$past(acc_in) && !carry_we_r;
    endproperty
    a_cpl_acc: assert property (p_cpl_acc) else $error("complement accumulator wrong");

    property p_carry_bit;
        @(posedge core_clk) disable iff (!nrst)
        take && (is_clrc || is_cplc) |=> done_r && carry_we_r
            && carry_r == ($past(is_cplc) && !$past(carry_in));
    endproperty
    a_carry_bit: assert property (p_carry_bit) else $error("carry bit op wrong");

    property p_bit_keeps_carry;
        @(posedge core_clk) disable iff (!nrst)
        take && (is_clrb || is_cplb) |=> done_r && !carry_we_r && res_r.wr_dst == DST_BIT
            && res_r.wr_addr == $past(issue.byte2);
    endproperty
    a_bit_keeps_carry: assert property (p_bit_keeps_carry) else $error("bit op hit carry");

    property p_port_latch;
        @(posedge core_clk) disable iff (!nrst)
        take && is_decr && !form_acc && opnd_is_port |=>
            res_r.wr_data == $past(opnd_latch) - 8'h01;
    endproperty
    a_port_latch: assert property (p_port_latch) else $error("port not read from latch");

    property p_adj_keeps_carry;
        @(posedge core_clk) disable iff (!nrst)
        take && is_adj && carry_in |=> done_r && carry_we_r && carry_r;
    endproperty
    a_adj_keeps_carry: assert property (p_adj_keeps_carry) else $error("adjust cleared carry");

    property p_decr_wrap;
        @(posedge core_clk) disable iff (!nrst)
        take && is_decr && form_acc && acc_in == 8'h00 |=> done_r && res_r.wr_data == 8'hFF
            && !carry_we_r;
    endproperty
    a_decr_wrap: assert property (p_decr_wrap) else $error("decrement wrap wrong");

    property p_reg_sel;
        @(posedge core_clk) disable iff (!nrst)
        take && is_decr && form_reg |=> res_r.wr_dst == DST_REG
            && res_r.wr_addr == {5'h00, $past(op[2:0])};
    endproperty
    a_reg_sel: assert property (p_reg_sel) else $error("register select wrong");

endmodule : cce_exec

// *** dv/testbench.sv ***
// self-checking bench for the compare/clear/complement/adjust/decrement unit
`timescale 1ns/1ps
module testbench;
    import cce_pkg::*;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic core_clk;
    logic nrst;
    logic issue_valid;
    cce_issue_t issue;
    logic [7:0] acc_in;
    logic carry_in;
    logic aux_carry_in;
    logic [7:0] opnd_pin;
    logic [7:0] opnd_latch;
    logic opnd_is_port;
    logic ready_r;
    logic done_r;
    cce_result_t res_r;
    logic [15:0] pc_next_r;
    logic carry_r;
    logic carry_we_r;
    int miscompares;
    int compares;
    int cycles;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] op;
    logic [7:0] adj_a [6] = '{8'hBE, 8'hC9, 8'h12, 8'h9A, 8'h45, 8'h99};
    logic [7:0] adj_r [6] = '{8'h24, 8'h29, 8'h18, 8'h00, 8'hA5, 8'h99};
    logic adj_aux [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic adj_cin [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
    logic adj_cout [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

    cce_exec dut (
        .core_clk(core_clk), .nrst(nrst), .issue_valid(issue_valid), .issue(issue),
        .acc_in(acc_in), .carry_in(carry_in), .aux_carry_in(aux_carry_in),
        .opnd_pin(opnd_pin), .opnd_latch(opnd_latch), .opnd_is_port(opnd_is_port),
        .ready_r(ready_r), .done_r(done_r), .res_r(res_r), .pc_next_r(pc_next_r),
        .carry_r(carry_r), .carry_we_r(carry_we_r)
    );

    // ------------------------------------------------------------
    // clock and watchdog
    // ------------------------------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // a run that reaches 3000 cycles is counted as a miscompare and ended; op_chk waits are bounded
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // issue one instruction, wait for its answer and compare the result fields that its expected enables and destination select
    task automatic op_chk(input logic [7:0] opc, b2, b3, input logic [15:0] pc,
            input logic [7:0] a, input logic cin, aux, input logic [7:0] pin, lat_v,
            input logic port, input logic en, input cce_dst_t dst, input logic [7:0] addr,
            input logic [7:0] data, input logic [15:0] epc, input logic cwe, ecar,
            input int elat, input logic ill);
        int n;
        @(posedge core_clk);
        #1;
        issue_valid = 1'b1;
        issue = '{opcode: opc, byte2: b2, byte3: b3, pc: pc};
        acc_in = a;
        carry_in = cin;
        aux_carry_in = aux;
        opnd_pin = pin;
        opnd_latch = lat_v;
        opnd_is_port = port;
        n = 0;
        while (ready_r !== 1'b1 && n < 20) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        @(posedge core_clk);
        #1;
        issue_valid = 1'b0;
        n = 1;
        while (done_r !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        chk("latency", elat[15:0], n[15:0]);
        chk("illegal", {15'h0000, ill}, {15'h0000, res_r.illegal});
        chk("wr_en", {15'h0000, en}, {15'h0000, res_r.wr_en});
        if (en) begin
            chk("wr_dst", 16'(dst), 16'(res_r.wr_dst));
            if (dst != DST_ACC)
                chk("wr_addr", {8'h00, addr}, {8'h00, res_r.wr_addr});
            if (dst == DST_BIT)
                chk("bit_data", {15'h0000, data[0]}, {15'h0000, res_r.wr_data[0]});
            else
                chk("wr_data", {8'h00, data}, {8'h00, res_r.wr_data});
        end
        chk("pc_next", epc, pc_next_r);
        chk("carry_we", {15'h0000, cwe}, {15'h0000, carry_we_r});
        if (cwe)
            chk("carry", {15'h0000, ecar}, {15'h0000, carry_r});
    endtask : op_chk

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        miscompares = 0;
        compares = 0;
        cycles = 0;
        nrst = 1'b0;
        issue_valid = 1'b0;
        issue = '0;
        acc_in = 8'h00;
        carry_in = 1'b0;
        aux_carry_in = 1'b0;
        opnd_pin = 8'h00;
        opnd_latch = 8'h00;
        opnd_is_port = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        nrst = 1'b1;
        // every compare form: below, above and equal, with a backward displacement
        for (int o = 8'hB4; o <= 8'hBF; o++) begin
            for (int k = 0; k < 3; k++) begin
                x = (k == 0) ? 8'h34 : ((k == 1) ? 8'h56 : 8'h7F);
                y = (k == 0) ? 8'h56 : ((k == 1) ? 8'h34 : 8'h7F);
                op = o[7:0];
                op_chk(op, (op == 8'hB5) ? 8'h11 : y, 8'hF0, 16'h1000,
                    (op <= 8'hB5) ? x : 8'hA5, ~(x < y), 1'b0, (op == 8'hB5) ? y : x, ~x, 1'b1,
                    1'b0, DST_NONE, 8'h00, 8'h00, (x != y) ? 16'h0FF3 : 16'h1003, 1'b1, x < y,
                    2, 1'b0);
            end
        end
        // accumulator clear and invert keep the flags; program counter wraps
        op_chk(OP_ZERO_ACC, 8'h00, 8'h00, 16'hFFFF, 8'h5C, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0,
            1'b1, DST_ACC, 8'h00, 8'h00, 16'h0000, 1'b0, 1'b0, 1, 1'b0);
        op_chk(OP_INV_ACC, 8'h00, 8'h00, 16'h2000, 8'h5C, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0,
            1'b1, DST_ACC, 8'h00, 8'hA3, 16'h2001, 1'b0, 1'b0, 1, 1'b0);
        // bit clear and bit invert on carry and on an addressable bit
        op_chk(OP_ZERO_CARRY, 8'h00, 8'h00, 16'h2000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0,
            1'b0, DST_NONE, 8'h00, 8'h00, 16'h2001, 1'b1, 1'b0, 1, 1'b0);
        op_chk(OP_ZERO_BIT, 8'h92, 8'h00, 16'h2000, 8'h00, 1'b1, 1'b0, 8'h01, 8'h01, 1'b0,
            1'b1, DST_BIT, 8'h92, 8'h00, 16'h2002, 1'b0, 1'b0, 1, 1'b0);
        op_chk(OP_INV_CARRY, 8'h00, 8'h00, 16'h2000, 8'h00, 1'b0, 1'b0, 8'h00, 8'h00, 1'b0,
            1'b0, DST_NONE, 8'h00, 8'h00, 16'h2001, 1'b1, 1'b1, 1, 1'b0);
        op_chk(OP_INV_CARRY, 8'h00, 8'h00, 16'h2000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0,
            1'b0, DST_NONE, 8'h00, 8'h00, 16'h2001, 1'b1, 1'b0, 1, 1'b0);
        op_chk(OP_INV_BIT, 8'h91, 8'h00, 16'h2000, 8'h00, 1'b1, 1'b0, 8'h01, 8'h00, 1'b1,
            1'b1, DST_BIT, 8'h91, 8'h01, 16'h2002, 1'b0, 1'b0, 1, 1'b0);
        op_chk(OP_INV_BIT, 8'h20, 8'h00, 16'h2000, 8'h00, 1'b1, 1'b0, 8'h01, 8'h00, 1'b0,
            1'b1, DST_BIT, 8'h20, 8'h00, 16'h2002, 1'b0, 1'b0, 1, 1'b0);
        // decimal adjust: every correction, carry kept once set
        for (int i = 0; i < 6; i++) begin
            op_chk(OP_ADJ_ACC, 8'h00, 8'h00, 16'h4000, adj_a[i], adj_cin[i], adj_aux[i],
                8'h00, 8'h00, 1'b0, 1'b1, DST_ACC, 8'h00, adj_r[i], 16'h4001, 1'b1, adj_cout[i],
                1, 1'b0);
        end
        // decrement on every operand form, wrapping at zero, flags untouched
        op_chk(8'h14, 8'h00, 8'h00, 16'h3000, 8'h00, 1'b1, 1'b1, 8'h00, 8'h00, 1'b0,
            1'b1, DST_ACC, 8'h00, 8'hFF, 16'h3001, 1'b0, 1'b0, 1, 1'b0);
        op_chk(8'h15, 8'h30, 8'h00, 16'h3000, 8'h00, 1'b1, 1'b1, 8'h05, 8'h05, 1'b0,
            1'b1, DST_DIRECT, 8'h30, 8'h04, 16'h3002, 1'b0, 1'b0, 1, 1'b0);
        op_chk(8'h15, 8'h90, 8'h00, 16'h3000, 8'h00, 1'b0, 1'b0, 8'h77, 8'h10, 1'b1,
            1'b1, DST_DIRECT, 8'h90, 8'h0F, 16'h3002, 1'b0, 1'b0, 1, 1'b0);
        for (int r = 0; r < 10; r++) begin
            op = (r < 2) ? 8'h16 + 8'(r) : 8'h18 + 8'(r - 2);
            op_chk(op, 8'h00, 8'h00, 16'h3000, 8'h00, 1'b1, 1'b1, 8'(r), 8'hEE, 1'b0,
                1'b1, (r < 2) ? DST_INDIRECT : DST_REG, (r < 2) ? 8'(r) : 8'(r - 2),
                8'(r) - 8'h01, 16'h3001, 1'b0, 1'b0, 1, 1'b0);
        end
        // an opcode outside the group writes nothing and steps past one byte
        op_chk(8'hA5, 8'h00, 8'h00, 16'h5000, 8'h00, 1'b1, 1'b0, 8'h00, 8'h00, 1'b0,
            1'b0, DST_NONE, 8'h00, 8'h00, 16'h5001, 1'b0, 1'b0, 1, 1'b1);
        end_sim();
    end

endmodule : testbench
